// ### common/xbus_params.svh
`ifndef XBUS_PARAMS_SVH
`define XBUS_PARAMS_SVH
// Oscillator periods per cycle type; one mclk edge is one oscillator period.
`define XBUS_DATA_CYCLE_LEN   3'd6
`define XBUS_CODE_CYCLE_LEN   3'd3
// Phase within a data cycle.
`define XBUS_DATA_ALE_END     3'd1
`define XBUS_DATA_STROBE_BEG  3'd2
`define XBUS_DATA_STROBE_END  3'd4
// Phase within a code cycle.
`define XBUS_CODE_ALE_END     3'd0
`define XBUS_CODE_STROBE_BEG  3'd1
// Reset values, and the port 0 latch load on access.
`define XBUS_P0_LATCH_RESET   8'hFF
`define XBUS_P0_LATCH_ACCESS  8'hFF
`define XBUS_P2_LATCH_RESET   8'hFF
`define XBUS_ALE_EN_RESET     1'b1
`endif

// ### common/xbus_pkg.sv
package xbus_pkg;
  typedef enum logic [1:0] {
    XBUS_IDLE = 2'b00,
    XBUS_CODE = 2'b01,
    XBUS_DATA = 2'b11
  } xbus_state_t;

  typedef enum logic [1:0] {
    XBUS_OP_NONE     = 2'b00,
    XBUS_OP_FETCH    = 2'b01,
    XBUS_OP_DATA_RD  = 2'b10,
    XBUS_OP_DATA_WR  = 2'b11
  } xbus_op_t;
endpackage

// ### logic/xbus_port_latch.sv
`timescale 1ns/100ps
`include "xbus_params.svh"
module xbus_port_latch #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] reset_value,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             force_en,
  input  wire logic [WIDTH-1:0] force_data,
  output logic      [WIDTH-1:0] q
);
  if (WIDTH < 1) begin : g_bad_width
    $error("xbus_port_latch: WIDTH must be positive");
  end

  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;
  logic             loaded_reg;

  // The forced load wins over a software write in the same cycle.
  always_comb begin
    q_next = q_reg;
    if (force_en) begin
      q_next = force_data;
    end else if (wr_en) begin
      q_next = wr_data;
    end
  end

  // The reset value is a port, so it is taken on the first edge after release.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_reg      <= '1;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      q_reg      <= force_en ? force_data : (wr_en ? wr_data : reset_value);
      loaded_reg <= 1'b1;
    end else begin
      q_reg      <= q_next;
    end
  end

  assign q = q_reg;
endmodule

// ### logic/xbus_ctrl.sv
`timescale 1ns/100ps
`include "xbus_params.svh"
module xbus_ctrl
  import xbus_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             external_code_select_n,
  input  wire logic             latch_strobe_enable_wr,
  input  wire logic             latch_strobe_enable_wdata,
  output logic                  latch_strobe_enable,
  input  wire xbus_pkg::xbus_op_t req_op,
  input  wire logic             req_wide,
  input  wire logic [15:0]      req_addr,
  input  wire logic [7:0]       req_wdata,
  output logic                  req_ready,
  output logic                  rsp_valid,
  output logic [7:0]            rsp_rdata,
  input  wire logic             p0_latch_wr,
  input  wire logic [7:0]       p0_latch_wdata,
  output logic [7:0]            p0_latch,
  input  wire logic             p2_latch_wr,
  input  wire logic [7:0]       p2_latch_wdata,
  output logic [7:0]            p2_latch,
  input  wire logic [7:0]       p0_in,
  output logic [7:0]            p0_out,
  output logic [7:0]            p0_oe,
  output logic [7:0]            p2_out,
  output logic [7:0]            p2_strong,
  output logic                  addr_latch_strobe,
  output logic                  program_read_strobe_n,
  output logic                  data_read_strobe_n,
  output logic                  data_write_strobe_n
);
  import xbus_pkg::*;

  // The phase compare points must fall inside their cycles, or a strobe would never end.
  if (`XBUS_CODE_CYCLE_LEN < 3'd2) begin : g_bad_code_len
    $error("xbus_ctrl: code cycle too short for address and strobe phases");
  end
  if (`XBUS_CODE_ALE_END >= `XBUS_CODE_CYCLE_LEN - 3'd1) begin : g_bad_code_ale
    $error("xbus_ctrl: code latch strobe must end before the cycle end");
  end
  if (`XBUS_DATA_ALE_END >= `XBUS_DATA_STROBE_BEG) begin : g_bad_data_ale
    $error("xbus_ctrl: data latch strobe must end before the data strobe");
  end
  if (`XBUS_DATA_STROBE_BEG >= `XBUS_DATA_STROBE_END) begin : g_bad_data_strobe
    $error("xbus_ctrl: data strobe must have a positive width");
  end
  if (`XBUS_DATA_STROBE_END >= `XBUS_DATA_CYCLE_LEN - 3'd1) begin : g_bad_data_end
    $error("xbus_ctrl: data strobe must rise before the response");
  end

  // The access load and the reset enable are fixed by the bus rules, not by taste.
  if (`XBUS_P0_LATCH_ACCESS != 8'hFF) begin : g_bad_p0_load
    $error("xbus_ctrl: port 0 latch must be loaded with all ones on access");
  end
  if (`XBUS_ALE_EN_RESET != 1'b1) begin : g_bad_ale_reset
    $error("xbus_ctrl: latch strobe generation must be enabled after reset");
  end

  typedef struct packed {
    xbus_state_t state;
    logic [2:0]  phase;
    logic        write;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        ale_en;
    logic        ale;
    logic        program_read_strobe_n_n;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  p0_out;
    logic        p0_drive;
    logic        addr_on_p2;
    logic [7:0]  p2_addr;
    logic        rsp_valid;
    logic [7:0]  rdata;
  } xbus_ctrl_st_t;

  xbus_ctrl_st_t s_reg;
  xbus_ctrl_st_t s_next;
  logic          start;
  logic          access_start;
  logic          code_addr_end;
  logic          code_last;
  logic          data_addr_end;
  logic          data_strobe_on;
  logic          data_strobe_off;
  logic          data_last;

  assign req_ready    = (s_reg.state == XBUS_IDLE);
  assign start        = req_ready && (req_op != XBUS_OP_NONE);
  assign access_start = start;

  // Phase points are decoded once, so every branch of the machine agrees on them.
  assign code_addr_end   = (s_reg.phase == `XBUS_CODE_ALE_END);
  assign code_last       = (s_reg.phase == `XBUS_CODE_CYCLE_LEN - 3'd1);
  assign data_addr_end   = (s_reg.phase == `XBUS_DATA_ALE_END);
  assign data_strobe_on  = (s_reg.phase == `XBUS_DATA_STROBE_BEG);
  assign data_strobe_off = (s_reg.phase == `XBUS_DATA_STROBE_END);
  assign data_last       = (s_reg.phase == `XBUS_DATA_CYCLE_LEN - 3'd1);

  // A data cycle drives the latch strobe in phases 0 and 1 and the data strobe low in
  // phases 3 and 4; a code cycle drives the latch strobe in phase 0 (not when the enable is clear and code is internal) and the program
  // strobe low in phases 1 and 2. The response pulse follows the last phase, and a new
  // request may be taken in that same cycle.

  always_comb begin
    s_next           = s_reg;
    s_next.rsp_valid = 1'b0;
    if (latch_strobe_enable_wr) begin
      s_next.ale_en = latch_strobe_enable_wdata;
    end
    case (s_reg.state)
      XBUS_IDLE: begin
        s_next.ale        = 1'b0;
        s_next.program_read_strobe_n_n     = 1'b1;
        s_next.rd_n       = 1'b1;
        s_next.wr_n       = 1'b1;
        s_next.p0_drive   = 1'b0;
        s_next.addr_on_p2 = 1'b0;
        if (start) begin
          s_next.phase    = 3'd0;
          s_next.addr     = req_addr;
          s_next.wdata    = req_wdata;
          s_next.write    = (req_op == XBUS_OP_DATA_WR);
          // Fetches always carry the high byte; data moves only when wide.
          s_next.wide     = (req_op == XBUS_OP_FETCH) || req_wide;
          s_next.p0_out   = req_addr[7:0];
          s_next.p0_drive = 1'b1;
          s_next.addr_on_p2 = s_next.wide;
          s_next.p2_addr  = req_addr[15:8];
          if (req_op == XBUS_OP_FETCH) begin
            s_next.state = XBUS_CODE;
            // Internal code with the enable clear suppresses the fetch latch strobe; the program strobe still runs.
            s_next.ale = s_reg.ale_en || !external_code_select_n;
          end else begin
            s_next.state = XBUS_DATA;
            s_next.ale   = 1'b1;
          end
        end
      end
      XBUS_CODE: begin
        s_next.phase = s_reg.phase + 3'd1;
        if (code_addr_end) begin
          s_next.ale    = 1'b0;
          s_next.program_read_strobe_n_n = 1'b0;
          s_next.p0_drive = 1'b0;
        end
        // The fetched byte is taken on the edge that raises the strobe, while it is driven.
        if (code_last) begin
          s_next.program_read_strobe_n_n     = 1'b1;
          s_next.rdata      = p0_in;
          s_next.rsp_valid  = 1'b1;
          s_next.addr_on_p2 = 1'b0;
          s_next.state      = XBUS_IDLE;
        end
      end
      XBUS_DATA: begin
        s_next.phase = s_reg.phase + 3'd1;
        if (data_addr_end) begin
          s_next.ale = 1'b0;
          if (s_reg.write) begin
            s_next.p0_out = s_reg.wdata;
          end else begin
            s_next.p0_drive = 1'b0;
          end
        end
        if (data_strobe_on) begin
          s_next.rd_n = s_reg.write;
          s_next.wr_n = !s_reg.write;
        end
        if (data_strobe_off) begin
          // Read data is taken before the strobe rises.
          if (!s_reg.write) begin
            s_next.rdata = p0_in;
          end
          s_next.rd_n = 1'b1;
          s_next.wr_n = 1'b1;
        end
        if (data_last) begin
          s_next.rsp_valid  = 1'b1;
          s_next.p0_drive   = 1'b0;
          s_next.addr_on_p2 = 1'b0;
          s_next.state      = XBUS_IDLE;
        end
      end
      default: begin
        s_next.state = XBUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // The struct is cleared first; idle-high strobes and the enable then override it.
      s_reg        <= '0;
      s_reg.state  <= XBUS_IDLE;
      s_reg.ale_en <= `XBUS_ALE_EN_RESET;
      s_reg.program_read_strobe_n_n <= 1'b1;
      s_reg.rd_n   <= 1'b1;
      s_reg.wr_n   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  xbus_port_latch #(
    .WIDTH(8)
  ) u_p0_latch (
    .mclk       (mclk),
    .rst        (rst),
    .reset_value(`XBUS_P0_LATCH_RESET),
    .wr_en      (p0_latch_wr),
    .wr_data    (p0_latch_wdata),
    .force_en   (access_start),
    .force_data (`XBUS_P0_LATCH_ACCESS),
    .q          (p0_latch)
  );

  // Port 2 latch has no forced load; an address on the pins never disturbs it.
  xbus_port_latch #(
    .WIDTH(8)
  ) u_p2_latch (
    .mclk       (mclk),
    .rst        (rst),
    .reset_value(`XBUS_P2_LATCH_RESET),
    .wr_en      (p2_latch_wr),
    .wr_data    (p2_latch_wdata),
    .force_en   (1'b0),
    .force_data (8'h00),
    .q          (p2_latch)
  );

  assign latch_strobe_enable   = s_reg.ale_en;
  assign addr_latch_strobe     = s_reg.ale;
  assign program_read_strobe_n = s_reg.program_read_strobe_n_n;
  assign data_read_strobe_n    = s_reg.rd_n;
  assign data_write_strobe_n   = s_reg.wr_n;
  assign p0_out    = s_reg.p0_out;
  // Each pin picks between the bus and its latch on its own, so one loop serves all.
  for (genvar b = 0; b < 8; b++) begin : g_pin
    assign p0_oe[b]     = s_reg.p0_drive;
    // Narrow accesses leave the paging byte from the latch on the pin.
    assign p2_out[b]    = s_reg.addr_on_p2 ? s_reg.p2_addr[b] : p2_latch[b];
    // A one address bit keeps its strong pull-up for the whole cycle.
    assign p2_strong[b] = s_reg.addr_on_p2 && s_reg.p2_addr[b];
  end
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_rdata = s_reg.rdata;
endmodule

// ### bench/xbus_mem_model.sv
`timescale 1ns/100ps
module xbus_mem_model (
  input  wire logic       mclk,
  input  wire logic       addr_latch_strobe,
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p2_out,
  input  wire logic       program_read_strobe_n,
  input  wire logic       data_read_strobe_n,
  input  wire logic       data_write_strobe_n,
  output logic      [7:0] p0_in
);
  logic [7:0] lo_reg, last_reg;
  logic [7:0] mem [0:65535];
  wire logic [15:0] addr = {p2_out, lo_reg};
  // Transparent while the strobe is high, closed once it falls; clocking it avoids a
  // race with port 0, which turns to write data on the edge where the strobe falls.
  always @(posedge mclk) if (addr_latch_strobe) lo_reg <= p0_out;
  always @(posedge data_write_strobe_n) mem[addr] = p0_out;
  always @(posedge mclk) last_reg <= p0_in;
  // A released bus shows a changing pattern so a stale byte is never read by luck.
  always_comb begin
    if (!program_read_strobe_n) p0_in = addr[7:0] ^ addr[15:8] ^ 8'hA5;
    else if (!data_read_strobe_n) p0_in = mem[addr];
    else p0_in = ~last_reg;
  end
endmodule

// ### bench/xbus_ctrl_checker.sv
`timescale 1ns/100ps
module xbus_ctrl_checker
  import xbus_pkg::*;
(
  input wire logic               mclk,
  input wire logic               rst,
  input wire xbus_pkg::xbus_op_t req_op,
  input wire logic               req_wide,
  input wire logic [15:0]        req_addr,
  input wire logic               req_ready,
  input wire logic               rsp_valid,
  input wire logic [7:0]         p2_latch,
  input wire logic [7:0]         p0_out,
  input wire logic [7:0]         p0_oe,
  input wire logic [7:0]         p2_out,
  input wire logic [7:0]         p2_strong,
  input wire logic               addr_latch_strobe,
  input wire logic               program_read_strobe_n,
  input wire logic               data_read_strobe_n,
  input wire logic               data_write_strobe_n
);
  import xbus_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [15:0] addr_reg;
  wire logic tk = req_ready && req_op != XBUS_OP_NONE;
  wire logic fe = tk && req_op == XBUS_OP_FETCH;
  wire logic dt = tk && req_op[1];
  always_ff @(posedge mclk) if (tk) addr_reg <= req_addr;
  property p_fetch; fe |=> (data_read_strobe_n && data_write_strobe_n)[*3] ##1 rsp_valid; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch used a data strobe");
  property p_program_read_strobe_n; fe |-> ##2 !program_read_strobe_n[*2] ##1 program_read_strobe_n; endproperty
  a_program_read_strobe_n: assert property (p_program_read_strobe_n) else $error("program strobe shape wrong");
  property p_rd; dt && !req_op[0] |-> ##4 !data_read_strobe_n[*2] ##2 rsp_valid; endproperty
  a_rd: assert property (p_rd) else $error("read strobe timing wrong");
  property p_fhi; fe |=> (p2_out == addr_reg[15:8] && p2_strong == addr_reg[15:8])[*3]; endproperty
  a_fhi: assert property (p_fhi) else $error("fetch high byte wrong");
  property p_wide; dt && req_wide |=> (p2_out == addr_reg[15:8])[*6]; endproperty
  a_wide: assert property (p_wide) else $error("wide high byte not held");
  property p_narrow; dt && !req_wide |=> (p2_out == p2_latch)[*6]; endproperty
  a_narrow: assert property (p_narrow) else $error("narrow access left latch");
  property p_p0; tk |=> p0_oe == 8'hFF && p0_out == addr_reg[7:0]; endproperty
  a_p0: assert property (p_p0) else $error("low address not driven");
  property p_ale; dt |=> addr_latch_strobe[*2] ##1 !addr_latch_strobe; endproperty
  a_ale: assert property (p_ale) else $error("data move lacks latch strobe");
  property p_busy; fe |=> !req_ready[*3] ##1 req_ready; endproperty
  a_busy: assert property (p_busy) else $error("busy window wrong");
  c_fetch: cover property (fe);
  c_wide: cover property (dt && req_wide);
  c_narrow: cover property (dt && !req_wide);
endmodule
bind xbus_ctrl xbus_ctrl_checker i_xbus_ctrl_checker (.*);

// ### bench/tb_xbus_ctrl.sv
`timescale 1ns/100ps
module tb_xbus_ctrl;
  import xbus_pkg::*;
  logic        mclk, rst, external_code_select_n, latch_strobe_enable_wr, latch_strobe_enable;
  logic        latch_strobe_enable_wdata, req_wide, req_ready, rsp_valid, p0_latch_wr;
  logic        p2_latch_wr, addr_latch_strobe, program_read_strobe_n, data_read_strobe_n;
  logic        data_write_strobe_n, en, ecs;
  logic [7:0]  req_wdata, rsp_rdata, p0_latch_wdata, p0_latch, p2_latch_wdata, p2_latch;
  logic [7:0]  p0_in, p0_out, p0_oe, p2_out, p2_strong, d, pv;
  logic [15:0] req_addr, a, ra;
  logic [31:0] seed;
  xbus_op_t    req_op;
  int          mismatches, checked, n, ale, ps, ds;
  xbus_ctrl      i_xbus_ctrl (.*);
  xbus_mem_model i_xbus_mem_model (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic c, input string m);
    checked++;
    if (c !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic op(input xbus_op_t o, input logic w, input logic [15:0] ad, input logic [7:0] wd);
    {n, ale, ps, ds} = '0;
    @(posedge mclk);
    req_op <= o;
    req_wide <= w;
    req_addr <= ad;
    req_wdata <= wd;
    @(posedge mclk);
    req_op <= XBUS_OP_NONE;
    #1;
    while (rsp_valid !== 1'b1 && n < 20) begin
      n++;
      ale += addr_latch_strobe;
      ps += !program_read_strobe_n;
      ds += !data_read_strobe_n + !data_write_strobe_n;
      @(posedge mclk);
      #1;
    end
  endtask
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  initial begin
    {rst, external_code_select_n, latch_strobe_enable_wr, latch_strobe_enable_wdata} = 4'hD;
    {p0_latch_wr, p2_latch_wr, req_wide, p0_latch_wdata, p2_latch_wdata} = '0;
    req_op = XBUS_OP_NONE;
    {req_addr, req_wdata} = '0;
    seed = 32'h5e8fb8b8;
    repeat (16) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    #1;
    chk(latch_strobe_enable === 1'b1 && p0_latch === 8'hFF && p2_latch === 8'hFF, "reset");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
      {pv, d} = seed[31:16];
      en = (i < 4) ? i[0] : seed[25];
      ecs = (i < 4) ? i[1] : seed[26];
      @(posedge mclk);
      {latch_strobe_enable_wr, p0_latch_wr, p2_latch_wr} <= 3'h7;
      {latch_strobe_enable_wdata, p0_latch_wdata, p2_latch_wdata} <= {en, ~d, pv};
      external_code_select_n <= ecs;
      @(posedge mclk);
      {latch_strobe_enable_wr, p0_latch_wr, p2_latch_wr} <= 3'h0;
      op(XBUS_OP_DATA_WR, seed[24], a, d);
      chk(n == 6 && ale == 2 && ps == 0 && ds == 2, "write cycle");
      chk(p0_latch === 8'hFF && p2_latch === pv, "port latches");
      ra = seed[24] ? a : {pv, a[7:0]};
      op(XBUS_OP_DATA_RD, 1'b1, ra, 8'h00);
      chk(n == 6 && rsp_rdata === d, "read back");
      op(XBUS_OP_FETCH, 1'b0, a, 8'h00);
      chk(n == 3 && ps == 2 && ds == 0 && ale == (en | !ecs), "fetch");
      chk(rsp_rdata === (a[7:0] ^ a[15:8] ^ 8'hA5), "fetch byte");
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule
